// File: host_model.sv
// Front-end host model: text records and step and pointer writes
module host_model (
   input  wire logic  clk_i,
   output logic       char_valid_o,
   output logic [7:0] char_o,
   output logic       step_wr_o,
   output logic [7:0] step_wdata_o,
   output logic       ptr_wr_o,
   output logic [15:0] ptr_wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {char_valid_o, step_wr_o, ptr_wr_o} = 3'b000;
      {char_o, step_wdata_o, ptr_wdata_o} = 32'h0;
   end
   function automatic logic [7:0] asc(input logic [3:0] n);
      asc = (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   task automatic put(input logic [7:0] c);
      @(negedge clk_i);
      char_o = c;
      char_valid_o = 1'b1;
      @(negedge clk_i);
      char_valid_o = 1'b0;
      char_o = ~c; // Idle line must not look like a held char
   endtask
   task automatic put_byte(input logic [7:0] b);
      put(asc(b[7:4]));
      put(asc(b[3:0]));
   endtask
   // Up to four data bytes, well inside one packet
   task automatic send_rec(input logic [7:0] n, input logic [15:0] a,
         input logic [7:0] t, input logic [31:0] d, input logic bad);
      logic [31:0] h;
      logic [7:0]  s;
      h = {n, a, t};
      s = 8'h00;
      put(8'h3a);
      for (int i = 0; i < 4; i++) begin
         put_byte(h[31-8*i -: 8]);
         s = s + h[31-8*i -: 8];
      end
      for (int i = 0; i < n; i++) begin
         put_byte(d[31-8*i -: 8]);
         s = s + d[31-8*i -: 8];
      end
      put_byte((8'h00 - s) ^ {7'h0, bad});
   endtask
   task automatic wr(input logic p, input logic [15:0] v);
      @(negedge clk_i);
      step_wdata_o = v[7:0];
      ptr_wdata_o = v;
      step_wr_o = !p;
      ptr_wr_o = p;
      @(negedge clk_i);
      {step_wr_o, ptr_wr_o} = 2'b00;
      step_wdata_o = ~v[7:0];
      ptr_wdata_o = ~v;
   endtask
endmodule // host_model

// File: loader_pkg.sv
// Package: constants and types for the firmware update resume loader
package loader_pkg;
   localparam logic [7:0]  STEP_NORMAL   = 8'h01;
   localparam logic [7:0]  STEP_PROGRAM  = 8'h1f;
   localparam logic [7:0]  STEP_ERASE    = 8'h3f;
   localparam logic [7:0]  STEP_INIT     = 8'h7f;
   localparam logic [7:0]  STEP_RESET    = 8'h00;
   localparam logic [15:0] BOOT_FLAG_ADDR = 16'h0000;
   localparam logic [7:0]  BOOT_FLAG_VAL = 8'hff;
   localparam logic [7:0]  CHAR_COLON    = 8'h3a;
   localparam logic [7:0]  SUM_GOOD      = 8'h00;
   localparam logic [15:0] PTR_RESET     = 16'h0000;
   localparam logic [7:0]  REC_DATA      = 8'h00;
   localparam logic [7:0]  REC_EOF       = 8'h01;
   localparam logic [7:0]  REC_EXT_SEG   = 8'h02;
   localparam logic [7:0]  REC_START_SEG = 8'h03;
   localparam logic [7:0]  REC_EXT_LIN   = 8'h04;
   localparam logic [7:0]  REC_START_LIN = 8'h05;
   localparam int          RECORD_MAX    = 256;

   typedef enum logic [6:0] {
      P_IDLE  = 7'b0000001,
      P_COUNT = 7'b0000010,
      P_ADDR  = 7'b0000100,
      P_TYPE  = 7'b0001000,
      P_DATA  = 7'b0010000,
      P_SUM   = 7'b0100000,
      P_DONE  = 7'b1000000
   } parse_state_t;

   typedef enum logic [2:0] {
      RT_DATA  = 3'd0,
      RT_EOF   = 3'd1,
      RT_ESEG  = 3'd2,
      RT_SSEG  = 3'd3,
      RT_ELIN  = 3'd4,
      RT_SLIN  = 3'd5,
      RT_OTHER = 3'd6
   } rec_kind_t;

   function automatic logic [3:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         hex_val = 4'(c - 8'h30);
      end else if (c >= 8'h41 && c <= 8'h46) begin
         hex_val = 4'(c - 8'h37);
      end else if (c >= 8'h61 && c <= 8'h66) begin
         hex_val = 4'(c - 8'h57);
      end else begin
         hex_val = 4'h0;
      end
   endfunction

   function automatic logic is_hex(input logic [7:0] c);
      is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
               || (c >= 8'h61 && c <= 8'h66);
   endfunction

   function automatic rec_kind_t decode_type(input logic [7:0] t);
      case (t)
         REC_DATA:      decode_type = RT_DATA;
         REC_EOF:       decode_type = RT_EOF;
         REC_EXT_SEG:   decode_type = RT_ESEG;
         REC_START_SEG: decode_type = RT_SSEG;
         REC_EXT_LIN:   decode_type = RT_ELIN;
         REC_START_LIN: decode_type = RT_SLIN;
         default:       decode_type = RT_OTHER;
      endcase
   endfunction
endpackage

// File: record_buf.sv
// Small memory holding one record's data bytes until the checksum is known
module record_buf #(
   parameter int AW = 8
) (
   input  wire logic   clk_i,
   record_buf_if.mem   bus
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [7:0] rd_q;

   always_ff @(posedge clk_i) begin
      if (bus.wr_en) begin
         mem[bus.wr_addr] <= bus.wr_data;
      end
      rd_q <= mem[bus.rd_addr];
   end

   assign bus.rd_data = rd_q;
endmodule // record_buf

// File: record_buf_if.sv
// Interface: write and read ports of the record data buffer
interface record_buf_if #(parameter int AW = 8);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [7:0]    wr_data;
   logic [AW-1:0] rd_addr;
   logic [7:0]    rd_data;
   modport owner (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
   modport mem   (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

// File: update_loader.sv
// Top: update step tracking, hex record parser and boot-loader mode select
module update_loader
   import loader_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        power_on_i,
   input  wire logic        jumper_i,
   input  wire logic [7:0]  boot_flag_byte_i,
   input  wire logic        step_wr_i,
   input  wire logic [7:0]  step_wdata_i,
   input  wire logic        ptr_wr_i,
   input  wire logic [15:0] ptr_wdata_i,
   input  wire logic        erase_done_i,
   input  wire logic        char_valid_i,
   input  wire logic [7:0]  char_i,
   output logic [7:0]       update_step_register_o,
   output logic [15:0]      program_location_pointer_o,
   output logic             boot_loader_mode_o,
   output logic             soft_reset_o,
   output logic             flash_wr_o,
   output logic [15:0]      flash_addr_o,
   output logic [7:0]       flash_data_o,
   output logic             rec_good_o,
   output logic             rec_bad_o,
   output logic             eof_seen_o
);
   // Buffer index and count are one byte wide, so only AW of 8 fits
   if (AW != 8) begin : g_aw_check
      $error("AW must be 8 to hold a 255 byte record");
   end

   // Jumper is a pin: three stage synchroniser, act when 2nd and 3rd agree
   logic [2:0] jmp_sync;
   logic       jmp_level;
   logic       next_jmp_level;
   always_comb begin
      next_jmp_level = jmp_level;
      if (jmp_sync[1] == jmp_sync[2]) next_jmp_level = jmp_sync[2];
   end
   always_ff @(posedge clk_i) begin
      jmp_sync  <= {jmp_sync[1:0], jumper_i};
      jmp_level <= next_jmp_level;
   end

   // Jumper latch clears only on power cycle, not on soft reset
   logic jumper_lock, next_jumper_lock;
   logic boot_sample, next_boot_sample;
   logic boot_flag, next_boot_flag;
   always_comb begin
      next_jumper_lock = jumper_lock;
      if (power_on_i) next_jumper_lock = 1'b0;
      else if (boot_sample && jmp_level) next_jumper_lock = 1'b1;
      next_boot_sample = sys_rst_i ? 1'b1 : 1'b0;
      next_boot_flag = boot_flag;
      if (boot_sample) begin
         next_boot_flag = (boot_flag_byte_i == BOOT_FLAG_VAL);
      end
   end
   always_ff @(posedge clk_i) begin
      jumper_lock <= next_jumper_lock;
      boot_sample <= next_boot_sample;
      boot_flag   <= next_boot_flag;
   end
   assign boot_loader_mode_o = boot_flag || jumper_lock;

   // Step register and pointer survive reset so the host can resume
   logic [7:0]  step, next_step;
   logic [15:0] ptr, next_ptr;
   logic        eof, next_eof;
   logic        srst, next_srst;

   parse_state_t st, next_st;
   logic [7:0]  count, next_count;
   logic [7:0]  idx, next_idx;
   logic [7:0]  sum, next_sum;
   logic [15:0] laddr, next_laddr;
   logic [7:0]  rtype, next_rtype;
   logic [3:0]  hi, next_hi;
   logic        half, next_half;
   logic [2:0]  nib, next_nib;
   logic [7:0]  good_cnt;
   logic        good, bad;

   record_buf_if #(.AW(AW)) rb ();
   record_buf #(.AW(AW)) u_buf (
      .clk_i (clk_i),
      .bus   (rb)
   );

   logic [7:0] byte_v;
   logic       byte_ok;
   assign byte_v  = {hi, hex_val(char_i)};
   assign byte_ok = char_valid_i && is_hex(char_i) && half;

   always_comb begin
      next_st    = st;
      next_count = count;
      next_idx   = idx;
      next_sum   = sum;
      next_laddr = laddr;
      next_rtype = rtype;
      next_hi    = hi;
      next_half  = half;
      next_nib   = nib;
      good = 1'b0;
      bad  = 1'b0;
      rb.wr_en   = 1'b0;
      rb.wr_addr = idx;
      rb.wr_data = byte_v;
      if (char_valid_i && char_i == CHAR_COLON) begin
         next_st   = P_COUNT;
         next_sum  = SUM_GOOD;
         next_half = 1'b0;
         next_nib  = 3'd0;
         next_idx  = 8'h00;
      end else if (char_valid_i && is_hex(char_i) && !half) begin
         next_hi   = hex_val(char_i);
         next_half = 1'b1;
      end else if (byte_ok) begin
         next_half = 1'b0;
         next_sum  = 8'(sum + byte_v);
         case (st)
            P_COUNT: begin
               next_count = byte_v;
               next_st    = P_ADDR;
               next_nib   = 3'd0;
            end
            P_ADDR: begin
               next_laddr = {laddr[7:0], byte_v};
               next_nib   = 3'(nib + 3'd1);
               if (nib == 3'd1) next_st = P_TYPE;
            end
            P_TYPE: begin
               next_rtype = byte_v;
               next_st    = (count == 8'h00) ? P_SUM : P_DATA;
            end
            P_DATA: begin
               rb.wr_en = 1'b1;
               next_idx = 8'(idx + 8'd1);
               if (8'(idx + 8'd1) == count) next_st = P_SUM;
            end
            P_SUM: begin
               next_st = P_DONE;
               if (8'(sum + byte_v) == SUM_GOOD) good = 1'b1;
               else bad = 1'b1;
            end
            P_IDLE, P_DONE: next_st = P_IDLE;
            default: next_st = P_IDLE;
         endcase
      end
   end

   // Good data record drains to flash one byte a cycle, only if the step is 1Fh when its checksum passes
   logic        drain, next_drain;
   logic [7:0]  d_idx, next_d_idx;
   logic        d_valid, next_d_valid;
   logic [15:0] d_addr, next_d_addr;
   rec_kind_t   kind;
   assign kind = decode_type(rtype);
   assign rb.rd_addr = d_idx;

   always_comb begin
      next_step  = step;
      next_ptr   = ptr;
      next_eof   = eof;
      next_srst  = 1'b0;
      next_drain = drain;
      next_d_idx = d_idx;
      next_d_valid = 1'b0;
      next_d_addr  = d_addr;
      if (good && kind == RT_DATA && step == STEP_PROGRAM) begin
         next_drain = (count != 8'h00);
         next_d_idx = 8'h00;
         next_ptr   = laddr;
      end
      if (drain) begin
         next_d_valid = 1'b1;
         next_d_addr  = 16'(laddr + {8'h00, d_idx});
         next_d_idx   = 8'(d_idx + 8'd1);
         if (8'(d_idx + 8'd1) == count) next_drain = 1'b0;
      end
      if (d_valid) next_ptr = 16'(d_addr + 16'd1);
      if (ptr_wr_i) next_ptr = ptr_wdata_i;
      if (step_wr_i) begin
         case (step_wdata_i)
            STEP_INIT: begin
               next_step = STEP_INIT;
               next_srst = 1'b1;
            end
            STEP_ERASE: next_step = STEP_ERASE;
            STEP_PROGRAM: next_step = STEP_PROGRAM;
            STEP_NORMAL: begin
               if (eof) begin
                  next_step = STEP_NORMAL;
                  next_srst = 1'b1;
                  next_eof  = 1'b0;
               end
            end
            default: next_step = step;
         endcase
      end
      // Set after the clear so a fresh end of file wins
      if (good && kind == RT_EOF) next_eof = 1'b1;
      // Erase stays 3Fh after done until the next step write, so an interrupted erase reads 3Fh
      if (erase_done_i && step == STEP_ERASE) next_step = STEP_ERASE;
   end

   always_ff @(posedge clk_i) begin
      if (power_on_i) begin
         step <= STEP_RESET;
         ptr  <= PTR_RESET;
      end else begin
         step <= next_step;
         ptr  <= next_ptr;
      end
      if (sys_rst_i) begin
         st      <= P_IDLE;
         count   <= 8'h00;
         idx     <= 8'h00;
         sum     <= SUM_GOOD;
         laddr   <= 16'h0000;
         rtype   <= 8'h00;
         hi      <= 4'h0;
         half    <= 1'b0;
         nib     <= 3'd0;
         eof     <= 1'b0;
         srst    <= 1'b0;
         drain   <= 1'b0;
         d_idx   <= 8'h00;
         d_valid <= 1'b0;
         d_addr  <= 16'h0000;
         good_cnt <= 8'h00;
      end else begin
         st      <= next_st;
         count   <= next_count;
         idx     <= next_idx;
         sum     <= next_sum;
         laddr   <= next_laddr;
         rtype   <= next_rtype;
         hi      <= next_hi;
         half    <= next_half;
         nib     <= next_nib;
         eof     <= next_eof;
         srst    <= next_srst;
         drain   <= next_drain;
         d_idx   <= next_d_idx;
         d_valid <= next_d_valid;
         d_addr  <= next_d_addr;
         good_cnt <= {7'h00, good};
      end
   end

   assign update_step_register_o     = step;
   assign program_location_pointer_o = ptr;
   assign soft_reset_o = srst;
   assign flash_wr_o   = d_valid;
   assign flash_addr_o = d_addr;
   assign flash_data_o = rb.rd_data;
   assign rec_good_o   = good_cnt[0];
   assign rec_bad_o    = bad;
   assign eof_seen_o   = eof;
endmodule // update_loader

// File: update_loader_checker.sv
// Checker: port-level properties of the update loader
module update_loader_checker (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        power_on_i,
   input wire logic        step_wr_i,
   input wire logic [7:0]  step_wdata_i,
   input wire logic        ptr_wr_i,
   input wire logic [15:0] ptr_wdata_i,
   input wire logic [7:0]  update_step_register_o,
   input wire logic [15:0] program_location_pointer_o,
   input wire logic        soft_reset_o,
   input wire logic        flash_wr_o,
   input wire logic        rec_bad_o,
   input wire logic        eof_seen_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i || power_on_i);
   step_src_a: assert property (
      !$stable(update_step_register_o) |-> $past(step_wr_i))
      else $error("step changed without a write");
   erase_write_a: assert property (
      step_wr_i && step_wdata_i == 8'h3f |=> update_step_register_o == 8'h3f)
      else $error("step not 3f after write");
   erase_hold_a: assert property (
      update_step_register_o == 8'h3f && !step_wr_i
      |=> update_step_register_o == 8'h3f)
      else $error("step left 3f without a write");
   program_write_a: assert property (
      step_wr_i && step_wdata_i == 8'h1f |=> update_step_register_o == 8'h1f)
      else $error("step not 1f after write");
   ptr_wr_a: assert property (
      ptr_wr_i |=> program_location_pointer_o == $past(ptr_wdata_i))
      else $error("pointer write lost");
   bad_rec_a: assert property (
      rec_bad_o |=> (!flash_wr_o && $stable(program_location_pointer_o))[*4])
      else $error("bad record changed flash or pointer");
   init_rst_a: assert property (
      step_wr_i && step_wdata_i == 8'h7f |-> ##[1:4] soft_reset_o)
      else $error("no reset request after 7f");
   eof_wr_a: assert property (
      eof_seen_o && step_wr_i && step_wdata_i == 8'h01
      |=> !eof_seen_o && update_step_register_o == 8'h01)
      else $error("01 after end of file not taken");
   early_wr_a: assert property (
      !eof_seen_o && step_wr_i && step_wdata_i == 8'h01
      |=> $stable(update_step_register_o))
      else $error("01 taken before end of file");
endmodule // update_loader_checker
bind update_loader update_loader_checker update_loader_checker_inst (.*);

// File: update_loader_tb_top.sv
// Testbench top for the update loader
module update_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, sys_rst_i, power_on_i, jumper_i, erase_done_i;
   logic        step_wr_i, ptr_wr_i, char_valid_i, flash_wr_o;
   logic [7:0]  boot_flag_byte_i, step_wdata_i, char_i;
   logic [7:0]  update_step_register_o, flash_data_o;
   logic [15:0] ptr_wdata_i, program_location_pointer_o, flash_addr_o;
   logic        boot_loader_mode_o, soft_reset_o;
   logic        rec_good_o, rec_bad_o, eof_seen_o;
   logic [23:0] fq[$];
   int          miscompares, checked, cyc, goods, bads, srsts;
   update_loader update_loader_inst (.*);
   host_model host_model_inst (
      .clk_i        (clk_i),
      .char_valid_o (char_valid_i),
      .char_o       (char_i),
      .step_wr_o    (step_wr_i),
      .step_wdata_o (step_wdata_i),
      .ptr_wr_o     (ptr_wr_i),
      .ptr_wdata_o  (ptr_wdata_i)
   );
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (flash_wr_o === 1'b1) fq.push_back({flash_addr_o, flash_data_o});
      goods += int'(rec_good_o === 1'b1);
      bads += int'(rec_bad_o === 1'b1);
      srsts += int'(soft_reset_o === 1'b1);
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rst(input logic p, input logic [7:0] f);
      @(negedge clk_i);
      boot_flag_byte_i = f;
      power_on_i = p;
      sys_rst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      {power_on_i, sys_rst_i} = 2'b00;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic rec(input logic [7:0] n, input logic [15:0] a,
         input logic [7:0] t, input logic [31:0] d, input logic bad);
      host_model_inst.send_rec(n, a, t, d, bad);
      repeat (8) @(negedge clk_i); // Lets the flash writes drain
   endtask
   task automatic t_boot();
      rst(1'b0, 8'hff);
      chk(boot_loader_mode_o, 1'b1);
      rst(1'b0, 8'h00);
      chk(boot_loader_mode_o, 1'b0);
   endtask
   task automatic t_erase();
      host_model_inst.wr(1'b0, 16'h3f);
      chk(update_step_register_o, 8'h3f);
      erase_done_i = 1'b1;
      @(negedge clk_i);
      erase_done_i = 1'b0;
      rst(1'b0, 8'h00);
      chk(update_step_register_o, 8'h3f);
   endtask
   task automatic t_prog();
      int b;
      host_model_inst.wr(1'b0, 16'h1f);
      host_model_inst.wr(1'b1, 16'h0010);
      fq.delete();
      rec(8'h02, 16'h0010, 8'h00, 32'haabb0000, 1'b0);
      chk(24'(fq.size()), 24'h2);
      chk(fq[0], 24'h0010aa);
      chk(fq[1], 24'h0011bb);
      chk(program_location_pointer_o, 16'h0012);
      rst(1'b0, 8'hff);
      chk(update_step_register_o, 8'h1f);
      chk(program_location_pointer_o, 16'h0012);
      host_model_inst.wr(1'b1, program_location_pointer_o);
      fq.delete();
      b = bads;
      rec(8'h01, 16'h0012, 8'h00, 32'h55000000, 1'b1);
      chk(24'(bads - b), 24'h1);
      chk(24'(fq.size()), 24'h0);
      chk(program_location_pointer_o, 16'h0012);
      host_model_inst.put(8'h3a);
      host_model_inst.put_byte(8'h0a); // Cut short by the next colon
      rec(8'h01, 16'h0012, 8'h00, 32'h66000000, 1'b0);
      chk(fq[0], 24'h001266);
      chk(program_location_pointer_o, 16'h0013);
   endtask
   task automatic t_types();
      int g;
      fq.delete();
      g = goods;
      for (int t = 2; t < 7; t++) begin
         rec(8'h02, 16'h0000, 8'(t), 32'h0, 1'b0);
      end
      chk(24'(goods - g), 24'h5);
      chk(24'(fq.size()), 24'h0);
      rec(8'h03, 16'h0000, 8'h00, 32'hff020000, 1'b0);
      chk(fq[0], 24'h0000ff);
   endtask
   task automatic t_eof();
      int s;
      host_model_inst.wr(1'b0, 16'h01);
      chk(update_step_register_o, 8'h1f);
      rec(8'h00, 16'h0000, 8'h01, 32'h0, 1'b0);
      chk(eof_seen_o, 1'b1);
      host_model_inst.wr(1'b0, 16'h01);
      chk(update_step_register_o, 8'h01);
      chk(eof_seen_o, 1'b0);
      fq.delete();
      rec(8'h01, 16'h0020, 8'h00, 32'h77000000, 1'b0);
      chk(24'(fq.size()), 24'h0);
      chk(program_location_pointer_o, 16'h0003);
      s = srsts;
      host_model_inst.wr(1'b0, 16'h7f);
      repeat (4) @(negedge clk_i);
      chk(update_step_register_o, 8'h7f);
      chk(24'(srsts - s), 24'h1);
   endtask
   task automatic t_jump();
      jumper_i = 1'b1;
      rst(1'b1, 8'h00);
      chk(boot_loader_mode_o, 1'b1);
      jumper_i = 1'b0;
      rst(1'b0, 8'h00);
      chk(boot_loader_mode_o, 1'b1);
      rst(1'b1, 8'h00);
      chk(boot_loader_mode_o, 1'b0);
   endtask
   initial begin
      {sys_rst_i, power_on_i, jumper_i, erase_done_i} = 4'b1100;
      boot_flag_byte_i = 8'h00;
      rst(1'b1, 8'h00);
      chk(update_step_register_o, 8'h00);
      chk(program_location_pointer_o, 16'h0000);
      t_boot();
      t_erase();
      t_prog();
      t_types();
      t_eof();
      t_jump();
      conclude();
   end
endmodule // update_loader_tb_top
